//--- rtl/rcd_pkg.sv
// constants and types shared by the core datapath files
package rcd_pkg;

    // ========================================================
    // timing
    // ========================================================
    localparam int CLK_PERIOD_NS = 8;       // core clock period
    localparam int INSTR_CYCLE_NS = 200;    // one instruction cycle
    // longest time, so rounded down; never below one cycle
    localparam int INSTR_CYCLES = (INSTR_CYCLE_NS / CLK_PERIOD_NS < 1) ?
        1 : INSTR_CYCLE_NS / CLK_PERIOD_NS;
    localparam int CYC_W = 5;                // width of the phase counter
    localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(INSTR_CYCLES - 1);

    // ========================================================
    // widths and depths
    // ========================================================
    localparam int IW = 14;                  // instruction word
    localparam int DW = 8;                   // data word
    localparam int PCW = 13;                 // program counter
    localparam int DAW = 9;                  // data memory address
    localparam int STK_DEPTH = 8;            // return address stack
    localparam int SPW = 3;                  // stack pointer width

    // ========================================================
    // mapped control register offsets (low 7 bits, every bank)
    // ========================================================
    localparam logic [6:0] ADR_INDIRECT = 7'h00;
    localparam logic [6:0] ADR_PC_LOW = 7'h02;
    localparam logic [6:0] ADR_STATUS = 7'h03;
    localparam logic [6:0] ADR_POINTER = 7'h04;
    localparam logic [6:0] ADR_PC_LATCH = 7'h0A;

    // ========================================================
    // status register fields and reset values
    // ========================================================
    localparam int ST_C = 0;                 // carry / inverted borrow-out
    localparam int ST_NC = 1;                // nibble_carry_flag
    localparam int ST_Z = 2;                 // zero
    localparam int ST_RP0 = 5;               // bank select low
    localparam int ST_RP1 = 6;               // bank select high
    localparam int ST_IRP = 7;               // indirect bank select
    localparam logic [7:0] STATUS_WMASK = 8'hE7;  // bits software writes
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [PCW-1:0] PC_RST = 13'h0000;
    localparam logic [IW-1:0] INSTR_NOP = 14'h0000;
    localparam logic [7:0] CODE_RETURN = 8'h08;
    localparam logic [7:0] CODE_RETURN_IE = 8'h09;

    // ========================================================
    // alu operations
    // ========================================================
    typedef enum logic [14:0] {
        ALU_PASS = 15'h0001,
        ALU_CLR  = 15'h0002,
        ALU_ADD  = 15'h0004,
        ALU_SUB  = 15'h0008,
        ALU_AND  = 15'h0010,
        ALU_IOR  = 15'h0020,
        ALU_XOR  = 15'h0040,
        ALU_COM  = 15'h0080,
        ALU_INC  = 15'h0100,
        ALU_DEC  = 15'h0200,
        ALU_RR   = 15'h0400,
        ALU_RL   = 15'h0800,
        ALU_SWAP = 15'h1000,
        ALU_BCLR = 15'h2000,
        ALU_BSET = 15'h4000
    } rcd_alu_op_e;

endpackage

//--- rtl/rcd_alu_if.sv
// operand and result bundle between the core and its alu
`timescale 1ns/1ps
`default_nettype none
interface rcd_alu_if;
    import rcd_pkg::*;
    logic [DW-1:0] a;        // first operand (file, literal or w)
    logic [DW-1:0] b;        // second operand, always w
    rcd_alu_op_e op;         // operation
    logic cin;               // carry in for rotates
    logic [2:0] bsel;        // bit index for bit ops
    logic [DW-1:0] y;        // result
    logic c;                 // carry out (borrow-out inverted on sub)
    logic nc;                // low nibble carry out
    logic z;                 // result is zero

    modport core (output a, b, op, cin, bsel, input y, c, nc, z);
    modport alu (input a, b, op, cin, bsel, output y, c, nc, z);
endinterface
`default_nettype wire

//--- rtl/rcd_alu.sv
// 8-bit alu of the core datapath
`timescale 1ns/1ps
`default_nettype none
module rcd_alu
    import rcd_pkg::*;
(
    rcd_alu_if.alu bus    // operands in, result and flags out
);

    // ========================================================
    // combinational operate
    // ========================================================
    logic [DW:0] sum;         // 9-bit sum for carry
    logic [4:0] nsum;         // low nibble sum for nibble carry

    // subtraction adds the one's complement plus one, so carry
    // comes out high when no borrow happened
    always_comb begin
        sum = {1'b0, bus.a} + {1'b0, bus.b};
        nsum = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
        bus.y = bus.a;
        bus.c = bus.cin;
        bus.nc = 1'b0;
        unique case (bus.op)
            ALU_PASS: bus.y = bus.a;
            ALU_CLR: bus.y = 8'h00;
            ALU_ADD: begin
                bus.y = sum[DW-1:0];
                bus.c = sum[DW];
                bus.nc = nsum[4];
            end
            ALU_SUB: begin
                sum = {1'b0, bus.a} + {1'b0, ~bus.b} + 9'h001;
                nsum = {1'b0, bus.a[3:0]} + {1'b0, ~bus.b[3:0]} + 5'h01;
                bus.y = sum[DW-1:0];
                bus.c = sum[DW];
                bus.nc = nsum[4];
            end
            ALU_AND: bus.y = bus.a & bus.b;
            ALU_IOR: bus.y = bus.a | bus.b;
            ALU_XOR: bus.y = bus.a ^ bus.b;
            ALU_COM: bus.y = ~bus.a;
            ALU_INC: bus.y = bus.a + 8'h01;
            ALU_DEC: bus.y = bus.a - 8'h01;
            ALU_RR: begin
                bus.y = {bus.cin, bus.a[7:1]};
                bus.c = bus.a[0];
            end
            ALU_RL: begin
                bus.y = {bus.a[6:0], bus.cin};
                bus.c = bus.a[7];
            end
            ALU_SWAP: bus.y = {bus.a[3:0], bus.a[7:4]};
            ALU_BCLR: bus.y = bus.a & ~(8'h01 << bus.bsel);
            ALU_BSET: bus.y = bus.a | (8'h01 << bus.bsel);
            default: bus.y = bus.a;
        endcase
        bus.z = (bus.y == 8'h00);
    end

endmodule
`default_nettype wire

//--- rtl/rcd_core.sv
// two-stage fetch/execute datapath of the 8-bit core
// Behaviour
// - fetch one 14-bit word per cycle
// - separate program and data buses, concurrent
// - fetch of next overlaps current execute
// - one instruction per cycle, branches take two
// - control registers mapped, direct and indirect reach
// - any operation on any register, any mode
// - 8-bit alu, add sub shift logic
// - operands are w and file or literal
// - w is 8-bit and has no address
// - instructions update carry, nibble carry, zero
// - subtraction carry flags mean no borrow
`timescale 1ns/1ps
`default_nettype none
module rcd_core
    import rcd_pkg::*;
(
    input wire logic i_mclk,                  // core clock, 125 MHz
    input wire logic i_reset_n,               // async reset, active low
    input wire logic i_ce,                    // clock enable, freezes all
    output logic [PCW-1:0] o_prog_addr,       // program memory address
    input wire logic [IW-1:0] i_prog_data,    // program word, async read
    output logic [DAW-1:0] o_dmem_addr,       // data memory address
    input wire logic [DW-1:0] i_dmem_rdata,   // data read, async read
    output logic [DW-1:0] o_dmem_wdata,       // data to write
    output logic o_dmem_we,                   // write strobe, one cycle
    output logic o_instr_tick,                // instruction cycle boundary
    output logic [DW-1:0] o_w,                // working accumulator
    output logic [DW-1:0] o_status            // status register
);

    // ========================================================
    // state
    // ========================================================
    logic [CYC_W-1:0] cyc_reg;                // phase in the cycle
    logic [PCW-1:0] pc_reg;                   // address being fetched
    logic [IW-1:0] ir_reg;                    // instruction executing
    logic ir_valid_reg;                       // low after a flush
    logic [DW-1:0] w_reg;                     // accumulator, unmapped
    logic [DW-1:0] status_reg;                // flags and bank bits
    logic [DW-1:0] fsr_reg;                   // indirect pointer
    logic [4:0] pclath_reg;                   // upper pc latch
    logic [PCW-1:0] stack_reg [STK_DEPTH];    // return addresses
    logic [SPW-1:0] sp_reg;                   // circular stack pointer

    rcd_alu_if alu_bus ();
    rcd_alu u_alu (.bus(alu_bus));

    // ========================================================
    // instruction cycle timing
    // ========================================================
    logic tick;      // last phase of the instruction cycle
    logic exec;      // a valid instruction retires this edge
    assign tick = (cyc_reg == CYC_LAST);
    assign exec = tick && i_ce && ir_valid_reg;
    assign o_instr_tick = tick;

    // phase counter, wraps once per instruction cycle
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cyc_reg <= '0;
        end else if (i_ce) begin
            cyc_reg <= tick ? '0 : cyc_reg + 5'h01;
        end
    end

    // ========================================================
    // decode
    // ========================================================
    logic [1:0] grp;          // top opcode group
    logic [3:0] sub;          // sub-opcode
    logic dbit;               // destination bit: 1 is file
    logic lit_sel, a_is_w;    // operand a source
    logic wr_w, wr_f;         // destinations
    logic up_c, up_nc, up_z;  // flag updates
    logic is_jump, is_call, is_ret, skip_zero;
    logic btf, btf_set;       // bit test and its skip sense
    assign grp = ir_reg[13:12];
    assign sub = ir_reg[11:8];
    assign dbit = ir_reg[7];

    always_comb begin
        alu_bus.op = ALU_PASS;
        lit_sel = 1'b0;
        a_is_w = 1'b0;
        wr_w = 1'b0;
        wr_f = 1'b0;
        {up_c, up_nc, up_z} = 3'b000;
        {is_jump, is_call, is_ret, skip_zero, btf, btf_set} = 6'h00;
        unique case (grp)
            // byte ops on file registers, any register any mode
            2'b00: begin
                wr_w = !dbit;
                wr_f = dbit;
                up_z = 1'b1;
                unique case (sub)
                    4'h0: begin
                        a_is_w = 1'b1;
                        up_z = 1'b0;
                        wr_w = 1'b0;
                        is_ret = !dbit && (ir_reg[7:0] == CODE_RETURN ||
                            ir_reg[7:0] == CODE_RETURN_IE);
                    end
                    4'h1: alu_bus.op = ALU_CLR;
                    4'h2: begin
                        alu_bus.op = ALU_SUB;
                        {up_c, up_nc} = 2'b11;
                    end
                    4'h3: alu_bus.op = ALU_DEC;
                    4'h4: alu_bus.op = ALU_IOR;
                    4'h5: alu_bus.op = ALU_AND;
                    4'h6: alu_bus.op = ALU_XOR;
                    4'h7: begin
                        alu_bus.op = ALU_ADD;
                        {up_c, up_nc} = 2'b11;
                    end
                    4'h8: alu_bus.op = ALU_PASS;
                    4'h9: alu_bus.op = ALU_COM;
                    4'hA: alu_bus.op = ALU_INC;
                    4'hB: begin
                        alu_bus.op = ALU_DEC;
                        {up_z, skip_zero} = 2'b01;
                    end
                    4'hC: begin
                        alu_bus.op = ALU_RR;
                        {up_z, up_c} = 2'b01;
                    end
                    4'hD: begin
                        alu_bus.op = ALU_RL;
                        {up_z, up_c} = 2'b01;
                    end
                    4'hE: begin
                        alu_bus.op = ALU_SWAP;
                        up_z = 1'b0;
                    end
                    4'hF: begin
                        alu_bus.op = ALU_INC;
                        {up_z, skip_zero} = 2'b01;
                    end
                endcase
            end
            // bit clear, set and tests
            2'b01: begin
                alu_bus.op = ir_reg[10] ? ALU_BSET : ALU_BCLR;
                wr_f = !ir_reg[11];
                btf = ir_reg[11];
                btf_set = ir_reg[10];
            end
            // jumps and calls take the extra cycle
            2'b10: begin
                is_jump = 1'b1;
                is_call = !ir_reg[11];
            end
            // literal ops
            2'b11: begin
                lit_sel = 1'b1;
                wr_w = 1'b1;
                up_z = 1'b1;
                if (sub[3:2] == 2'b00) begin
                    up_z = 1'b0;
                end else if (sub[3:2] == 2'b01) begin
                    {up_z, is_ret} = 2'b01;
                end else if (sub[3:1] == 3'b110) begin
                    alu_bus.op = ALU_SUB;
                    {up_c, up_nc} = 2'b11;
                end else if (sub[3:1] == 3'b111) begin
                    alu_bus.op = ALU_ADD;
                    {up_c, up_nc} = 2'b11;
                end else begin
                    alu_bus.op = sub[1] ? ALU_XOR :
                        (sub[0] ? ALU_AND : ALU_IOR);
                end
            end
        endcase
    end

    // ========================================================
    // data memory addressing and read mux
    // ========================================================
    logic [DAW-1:0] eaddr;    // effective data address
    logic [DW-1:0] fval;      // file register value
    logic local_hit;          // address is a mapped control register
    logic [PCW-1:0] pc_exec;  // address of the executing instruction
    assign pc_exec = pc_reg - 13'h0001;

    // direct uses the bank bits, indirect uses the pointer
    always_comb begin
        if (ir_reg[6:0] == ADR_INDIRECT) begin
            eaddr = {status_reg[ST_IRP], fsr_reg};
        end else begin
            eaddr = {status_reg[ST_RP1], status_reg[ST_RP0], ir_reg[6:0]};
        end
        local_hit = 1'b1;
        unique case (eaddr[6:0])
            ADR_INDIRECT: fval = 8'h00;     // self-pointing reads zero
            ADR_PC_LOW: fval = pc_exec[7:0];
            ADR_STATUS: fval = status_reg;
            ADR_POINTER: fval = fsr_reg;
            ADR_PC_LATCH: fval = {3'b000, pclath_reg};
            default: begin
                fval = i_dmem_rdata;
                local_hit = 1'b0;
            end
        endcase
    end

    assign alu_bus.a = lit_sel ? ir_reg[7:0] : (a_is_w ? w_reg : fval);
    assign alu_bus.b = w_reg;
    assign alu_bus.cin = status_reg[ST_C];
    assign alu_bus.bsel = ir_reg[9:7];

    // data bus runs beside the program bus in the same cycle
    assign o_dmem_addr = eaddr;
    assign o_dmem_wdata = alu_bus.y;
    assign o_dmem_we = exec && wr_f && !local_hit;

    // ========================================================
    // control flow
    // ========================================================
    logic skip, pcl_wr, flush;
    logic [PCW-1:0] pc_next;
    assign skip = (skip_zero && alu_bus.z) ||
        (btf && (fval[ir_reg[9:7]] == btf_set));
    assign pcl_wr = wr_f && (eaddr[6:0] == ADR_PC_LOW);
    assign flush = is_jump || is_ret || skip || pcl_wr;

    always_comb begin
        pc_next = pc_reg + 13'h0001;
        if (is_jump) begin
            pc_next = {pclath_reg[4:3], ir_reg[10:0]};
        end else if (is_ret) begin
            pc_next = stack_reg[sp_reg - 3'h1];
        end else if (pcl_wr) begin
            pc_next = {pclath_reg, alu_bus.y};
        end
    end

    // fetch runs every cycle while the current word executes
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pc_reg <= PC_RST;
            ir_reg <= INSTR_NOP;
            ir_valid_reg <= 1'b0;
        end else if (tick && i_ce) begin
            ir_reg <= i_prog_data;
            pc_reg <= (ir_valid_reg) ? pc_next : pc_reg + 13'h0001;
            ir_valid_reg <= !(ir_valid_reg && flush);
        end
    end
    assign o_prog_addr = pc_reg;

    // return stack pointer, wraps silently when overfilled
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sp_reg <= '0;
        end else if (exec && is_call) begin
            sp_reg <= sp_reg + 3'h1;
        end else if (exec && is_ret) begin
            sp_reg <= sp_reg - 3'h1;
        end
    end

    // return addresses need no reset, a call writes before any use
    always_ff @(posedge i_mclk) begin
        if (exec && is_call) begin
            stack_reg[sp_reg] <= pc_reg;
        end
    end

    // ========================================================
    // register writes
    // ========================================================
    // accumulator has no data address, only w-destination ops load it
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            w_reg <= 8'h00;
        end else if (exec && wr_w) begin
            w_reg <= alu_bus.y;
        end
    end

    // pointer and pc latch are ordinary file targets
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fsr_reg <= 8'h00;
            pclath_reg <= 5'h00;
        end else if (exec && wr_f) begin
            if (eaddr[6:0] == ADR_POINTER) begin
                fsr_reg <= alu_bus.y;
            end
            if (eaddr[6:0] == ADR_PC_LATCH) begin
                pclath_reg <= alu_bus.y[4:0];
            end
        end
    end

    // flag updates win over a direct write to the same bits
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status_reg <= STATUS_RST;
        end else if (exec) begin
            if (wr_f && eaddr[6:0] == ADR_STATUS) begin
                status_reg <= (status_reg & ~STATUS_WMASK) |
                    (alu_bus.y & STATUS_WMASK);
            end
            if (up_c) begin
                status_reg[ST_C] <= alu_bus.c;
            end
            if (up_nc) begin
                status_reg[ST_NC] <= alu_bus.nc;
            end
            if (up_z) begin
                status_reg[ST_Z] <= alu_bus.z;
            end
        end
    end
    assign o_w = w_reg;
    assign o_status = status_reg;

    // ========================================================
    // checks
    // ========================================================
    chk_cycle_len: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (tick && i_ce) |=> (cyc_reg == 5'h00) [*1] ##0 !tick)
        else $error("instruction cycle length wrong");
    chk_fetch_step: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (tick && i_ce && !(ir_valid_reg && flush)) |=>
            (pc_reg == $past(pc_reg) + 13'h0001) && ir_valid_reg)
        else $error("fetch did not advance");
    chk_branch_flush: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (exec && is_jump) |=> !ir_valid_reg &&
            pc_reg[10:0] == $past(ir_reg[10:0]))
        else $error("branch did not flush");
    chk_w_unmapped: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (exec && wr_w) |-> !o_dmem_we)
        else $error("accumulator write reached data bus");
    chk_zero_flag: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (exec && up_z) |=> status_reg[ST_Z] ==
            ($past(alu_bus.y) == 8'h00))
        else $error("zero flag wrong");
    chk_sub_borrow: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (exec && alu_bus.op == ALU_SUB) |=> status_reg[ST_C] ==
            ($past(alu_bus.a) >= $past(alu_bus.b)))
        else $error("borrow flag wrong");
    chk_add_sum: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (alu_bus.op == ALU_ADD) |-> {alu_bus.c, alu_bus.y} ==
            {1'b0, alu_bus.a} + {1'b0, alu_bus.b})
        else $error("add result wrong");
    chk_indirect_addr: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (ir_reg[6:0] == ADR_INDIRECT && grp != 2'b11) |->
            o_dmem_addr == {status_reg[ST_IRP], fsr_reg})
        else $error("indirect address wrong");

endmodule
`default_nettype wire

//--- tb/rcd_mem_model.sv
// program and data memories on the far side of the core datapath
`timescale 1ns/1ps
`default_nettype none
module rcd_mem_model
    import rcd_pkg::*;
(
    input wire logic i_mclk,                  // core clock
    input wire logic i_ce,                    // clock enable
    input wire logic [PCW-1:0] i_prog_addr,   // fetch address
    output logic [IW-1:0] o_prog_data,        // fetched word
    input wire logic [DAW-1:0] i_dmem_addr,   // data address
    output logic [DW-1:0] o_dmem_rdata,       // read data
    input wire logic [DW-1:0] i_dmem_wdata,   // write data
    input wire logic i_dmem_we                // write strobe
);
    // ========================================================
    // storage
    // ========================================================
    logic [IW-1:0] prog [0:(1<<PCW)-1];       // whole 14-bit words
    logic [DW-1:0] data [0:(1<<DAW)-1];       // byte store
    // separate async buses, so fetch and data access overlap
    assign o_prog_data = prog[i_prog_addr];
    assign o_dmem_rdata = data[i_dmem_addr];
    // write lands only on an enabled edge
    always_ff @(posedge i_mclk) begin
        if (i_ce && i_dmem_we) begin
            data[i_dmem_addr] <= i_dmem_wdata;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench: random add and subtract programs
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rcd_pkg::*;
    logic clk = 1'b0;                // core clock
    logic rst_n = 1'b0;              // reset, active low
    logic ce = 1'b1;                 // clock enable
    logic [PCW-1:0] paddr;
    logic [IW-1:0] pdata;
    logic [DAW-1:0] daddr;
    logic [DW-1:0] rdata, wdata, w, st;
    logic we, tick;
    integer seed = 32'h148A7171;
    int fail_count = 0;
    int num_checks = 0;
    int pcw = 0;                     // next program slot
    logic [4:0] cnt = 5'h00;         // enabled edges since last tick
    logic [7:0] a_q [0:19];
    logic [7:0] b_q [0:19];
    // indirect store, then a decrement that must skip the next word
    logic [IW-1:0] ext [10] = '{14'h3070, 14'h0084, 14'h305A, 14'h0080,
        14'h3001, 14'h00F2, 14'h3011, 14'h0BF2, 14'h30EE, 14'h00F3};
    always #4 clk = ~clk;
    rcd_core dut_u (.i_mclk(clk), .i_reset_n(rst_n), .i_ce(ce),
        .o_prog_addr(paddr), .i_prog_data(pdata), .o_dmem_addr(daddr),
        .i_dmem_rdata(rdata), .o_dmem_wdata(wdata), .o_dmem_we(we),
        .o_instr_tick(tick), .o_w(w), .o_status(st));
    rcd_mem_model mem_u (.i_mclk(clk), .i_ce(ce), .i_prog_addr(paddr),
        .o_prog_data(pdata), .i_dmem_addr(daddr), .o_dmem_rdata(rdata),
        .i_dmem_wdata(wdata), .i_dmem_we(we));
    // ========================================================
    // helpers
    // ========================================================
    task automatic check(input string what, input logic [7:0] e,
            input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s exp %h got %h", what, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic emit(input logic [IW-1:0] wd);
        mem_u.prog[pcw] = wd;
        pcw++;
    endtask
    // status as read back: fixed ones in bits 3 and 4, bank 0
    function automatic logic [7:0] flags(input logic c, input logic n,
            input logic [7:0] y);
        return {5'b00011, y == 8'h00, n, c};
    endfunction
    // random clock enable gaps; only enabled edges count
    always @(negedge clk) ce <= ($random(seed) % 8) != 0;
    // instruction cycle length and write strobe placement
    always @(posedge clk) begin
        if (rst_n && ce) begin
            if (we) check("we on tick", 8'h01, {7'h00, tick});
            if (tick) begin
                check("tick period", INSTR_CYCLES, cnt + 5'h01);
                cnt <= 5'h00;
            end else begin
                cnt <= cnt + 5'h01;
            end
        end
    end
    // ========================================================
    // main sequence
    // ========================================================
    initial begin
        logic [6:0] r;
        logic [8:0] s;
        logic [7:0] a, b;
        int k;
        int park;
        for (int i = 0; i < (1 << PCW); i++) mem_u.prog[i] = INSTR_NOP;
        a_q[0:4] = '{8'h00, 8'hFF, 8'h0F, 8'h00, 8'h80};
        b_q[0:4] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h80};
        for (int i = 5; i < 20; i++) begin
            a_q[i] = $random(seed);
            b_q[i] = $random(seed);
        end
        // per test: add into a file, save flags, k - w, save flags
        for (int i = 0; i < 20; i++) begin
            r = 7'h20 + 7'(4 * i);
            emit(14'h3000 | a_q[i]);
            emit(14'h0080 | r);
            emit(14'h3000 | b_q[i]);
            emit(14'h0780 | r);
            emit(14'h0803);
            emit(14'h0080 | (r + 7'h01));
            emit(14'h3000 | b_q[i]);
            emit(14'h3C00 | a_q[i]);
            emit(14'h0080 | (r + 7'h02));
            emit(14'h0803);
            emit(14'h0080 | (r + 7'h03));
        end
        foreach (ext[j]) emit(ext[j]);
        emit(14'h2000 | 14'(pcw + 3));
        emit(14'h00F1);
        park = pcw;
        emit(14'h2800 | 14'(pcw));   // park on a jump to itself
        emit(14'h3400 | 14'h003C);   // subroutine: return with a literal
        repeat (20) @(negedge clk);
        check("status rst", STATUS_RST, st);
        check("w rst", 8'h00, w);
        rst_n = 1'b1;
        k = 0;
        while (paddr !== PCW'(park) && k < 20000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 20000) begin
            fail_count++;   // a hang counts as a mismatch
        end
        repeat (100) @(negedge clk);
        for (int i = 0; i < 20; i++) begin
            r = 7'h20 + 7'(4 * i);
            a = a_q[i];
            b = b_q[i];
            s = a + b;
            check("sum", s[7:0], mem_u.data[r]);
            check("add flags",
                flags(s[8], a[3:0] + b[3:0] > 15, s[7:0]),
                mem_u.data[r + 1]);
            s = {1'b0, a} - {1'b0, b};
            check("diff", s[7:0], mem_u.data[r + 2]);
            check("sub flags",
                flags(!s[8], a[3:0] >= b[3:0], s[7:0]),
                mem_u.data[r + 3]);
            $display("test %0d done", i);
        end
        check("w", 8'h3C, w);
        check("status",
            flags(!s[8], a[3:0] >= b[3:0], 8'h01), st);
        check("indirect", 8'h5A, mem_u.data[9'h070]);
        check("skip", 8'h11, mem_u.data[9'h073]);
        check("dec", 8'h00, mem_u.data[9'h072]);
        check("call", 8'h3C, mem_u.data[9'h071]);
        $display("test extra done");
        end_sim();
    end
endmodule
`default_nettype wire
